/* File: pkg/lcd_timing_defs.svh */
// Offsets, field positions, reset values and timing counts of the panel timer.
// Included by lcd_panel_timing, shift_wave and the testbench; definitions only.
//
// Operation
// - Active part of a line lasts (width field + 1) x 8 pixel clocks.
// - Blank part of a line lasts (blank field + 4) x 8 pixel clocks.
// - Frame carries 10-bit height plus one display lines, split over two registers.
// - After the display lines, 6-bit blank field lines follow each frame.
// - Frame pulse rises at least line period minus 9 before line falling edge.
// - Frame pulse stays high at least 9 pixel clocks past line falling edge.
// - Line pulse is high at least 9 pixel clocks.
// - In 4-bit and one-clock 8-bit modes, bias toggles 1 clock after line rise.
// - Shift clocks idle at least 23 pixel clocks after the line falling edge.
// - First shift fall follows first rise by 0.5 (4-bit) or 2 (one-clock).
// - 4-bit mode uses upper four data lines, shift at pixel rate, half duty.
// - 4-bit last shift fall leads line rise by field x8+0.5, fall by +9.5.
// - Two-clock 8-bit mode runs two shift clocks, period 4, two low two high.
// - Two-clock mode first primary rise and second fall at idle time plus 2.
// - Two-clock mode data valid 1 clock before and after each shift fall.
// - Two-clock mode last second fall leads line fall by field x8 plus 11.
// - One-clock 8-bit mode shift period 2, one low one high, data held 1 around.
// - One-clock mode last fall leads line rise by field x8+1, fall by +10; the code gives x8+2 and +11.
`ifndef LCD_TIMING_DEFS_SVH
`define LCD_TIMING_DEFS_SVH

`define HACT_WIDTH_OFF 8'h04
`define VACT_LOW_OFF 8'h05
`define VACT_HIGH_OFF 8'h06
`define HBLANK_OFF 8'h08
`define VBLANK_OFF 8'h0A
`define STATUS_OFF 8'h0C

`define HACT_FIELD_MSB 6
`define VACT_HIGH_MSB 1
`define HBLANK_FIELD_MSB 4
`define VBLANK_FIELD_MSB 5

`define REG_RESET 8'h00

`define UNIT_TICKS 8
`define HBLANK_EXTRA 4
`define LINE_PULSE_TICKS 9
`define FRAME_HOLD_TICKS 9
`define SHIFT_IDLE_TICKS 23
`define TWO_CLK_LEAD 2

`endif

/* File: pkg/lcd_timing_pkg.sv */
// Types shared by the panel timer and its helper modules.
// Assumes nothing of its surroundings.
package lcd_timing_pkg;

  typedef enum logic [1:0] {
    MODE_4BIT,
    MODE_8BIT_TWO_CLK,
    MODE_8BIT_ONE_CLK
  } panel_mode_e;

  typedef logic [10:0] hpos_t;

endpackage

/* File: src/lcd_panel_timing.sv */
// Passive colour panel timing generator: frame, line, shift, bias, data.
// Assumes pixel_data comes from logic on clk and the pixel clock from a pin.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_timing_defs.svh"
module lcd_panel_timing
  import lcd_timing_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic pixel_clock_pin,
  input wire panel_mode_e panel_mode,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pixel_data,
  output logic pixel_take,
  output logic frame_pulse,
  output logic line_pulse,
  output logic shift_clock,
  output logic shift_clock_2,
  output logic backplane_bias_alternate,
  output logic [7:0] panel_pixel_bus
);
  logic [7:0] horizontal_display_width_reg;
  logic [7:0] vertical_display_height_low_reg;
  logic [7:0] vertical_display_height_high_reg;
  logic [7:0] horizontal_blank_length_reg;
  logic [7:0] vertical_blank_length_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  hpos_t pos_reg;
  hpos_t pos_next;
  logic [10:0] line_reg;
  logic [10:0] line_next;
  logic line_pulse_reg;
  logic line_pulse_next;
  logic frame_reg;
  logic frame_next;
  logic bias_reg;
  logic bias_next;
  logic shift_a_reg;
  logic shift_b_reg;
  logic [7:0] data_reg;
  logic [7:0] data_next;

  logic pclk_level;
  logic pclk_rise;

  // Decoded register strobes
  logic wr_hact;
  logic wr_vlow;
  logic wr_vhigh;
  logic wr_hblank;
  logic wr_vblank;
  assign wr_hact = reg_wr && (reg_addr == `HACT_WIDTH_OFF);
  assign wr_vlow = reg_wr && (reg_addr == `VACT_LOW_OFF);
  assign wr_vhigh = reg_wr && (reg_addr == `VACT_HIGH_OFF);
  assign wr_hblank = reg_wr && (reg_addr == `HBLANK_OFF);
  assign wr_vblank = reg_wr && (reg_addr == `VBLANK_OFF);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      horizontal_display_width_reg <= `REG_RESET;
      vertical_display_height_low_reg <= `REG_RESET;
      vertical_display_height_high_reg <= `REG_RESET;
      horizontal_blank_length_reg <= `REG_RESET;
      vertical_blank_length_reg <= `REG_RESET;
    end else begin
      if (wr_hact) begin
        horizontal_display_width_reg <= reg_wdata;
      end
      if (wr_vlow) begin
        vertical_display_height_low_reg <= reg_wdata;
      end
      if (wr_vhigh) begin
        vertical_display_height_high_reg <= reg_wdata;
      end
      if (wr_hblank) begin
        horizontal_blank_length_reg <= reg_wdata;
      end
      if (wr_vblank) begin
        vertical_blank_length_reg <= reg_wdata;
      end
    end
  end

  // Register readback, status shows the low eight bits of the current line number
  always_comb begin
    case (reg_addr)
      `HACT_WIDTH_OFF: rdata_next = horizontal_display_width_reg;
      `VACT_LOW_OFF: rdata_next = vertical_display_height_low_reg;
      `VACT_HIGH_OFF: rdata_next = vertical_display_height_high_reg;
      `HBLANK_OFF: rdata_next = horizontal_blank_length_reg;
      `VBLANK_OFF: rdata_next = vertical_blank_length_reg;
      `STATUS_OFF: rdata_next = line_reg[7:0];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // Line and frame geometry in pixel clocks and lines
  hpos_t hact_ticks;
  hpos_t hblank_ticks;
  hpos_t line_len;
  logic [10:0] vact_lines;
  logic [10:0] frame_lines;
  logic [6:0] hact_field;
  logic [4:0] hblank_field;
  logic [9:0] vact_field;
  logic [5:0] vblank_field;

  assign hact_field = horizontal_display_width_reg[`HACT_FIELD_MSB:0];
  assign hblank_field = horizontal_blank_length_reg[`HBLANK_FIELD_MSB:0];
  assign vact_field = {vertical_display_height_high_reg[`VACT_HIGH_MSB:0],
                       vertical_display_height_low_reg};
  assign vblank_field = vertical_blank_length_reg[`VBLANK_FIELD_MSB:0];
  assign hact_ticks = hpos_t'(({4'h0, hact_field} + 11'h001)
                      * `UNIT_TICKS);
  assign hblank_ticks = hpos_t'(({6'h00, hblank_field} + `HBLANK_EXTRA)
                        * `UNIT_TICKS);
  assign line_len = hact_ticks + hblank_ticks;
  assign vact_lines = {1'b0, vact_field} + 11'h001;
  assign frame_lines = vact_lines + {5'h00, vblank_field};

  pclk_edge u_pclk_edge (
    .clk(clk),
    .resetn(resetn),
    .pixel_clock_pin(pixel_clock_pin),
    .pclk_level(pclk_level),
    .pclk_rise(pclk_rise)
  );

  // Position counters, wrapped at the end of each line and frame
  logic last_pos;
  logic last_line;
  assign last_pos = (pos_reg >= line_len - 11'h001);
  assign last_line = (line_reg >= frame_lines - 11'h001);
  assign pos_next = last_pos ? 11'h000 : pos_reg + 11'h001;
  assign line_next = !last_pos ? line_reg :
                     (last_line ? 11'h000 : line_reg + 11'h001);

  // Line pulse occupies the last nine clocks; its fall starts a line
  hpos_t rise_pos;
  hpos_t hold_pos;
  assign rise_pos = line_len - hpos_t'(`LINE_PULSE_TICKS);
  assign hold_pos = hpos_t'(`FRAME_HOLD_TICKS);
  assign line_pulse_next = (pos_next >= rise_pos);
  // Frame pulse from clock 9 of the last line to clock 9 of line 0
  assign frame_next = ((line_next == frame_lines - 11'h001)
                      && (pos_next >= hold_pos))
                      || ((line_next == 11'h000)
                      && (pos_next < hold_pos));
  // Bias flips one clock after the line pulse rises
  assign bias_next = (pos_next == rise_pos + 11'h001) ? ~bias_reg
                     : bias_reg;

  // Shift window: display lines only, after the idle time
  hpos_t idle_pos;
  hpos_t q_pos;
  logic run;
  logic shift_a;
  logic shift_b;
  logic load;
  assign idle_pos = hpos_t'(`SHIFT_IDLE_TICKS);
  assign q_pos = pos_next - idle_pos;
  assign run = (line_next < vact_lines) && (pos_next >= idle_pos);

  shift_wave u_shift_wave (
    .mode(panel_mode),
    .run(run),
    .q(q_pos),
    .span(hact_ticks),
    .shift_a(shift_a),
    .shift_b(shift_b),
    .load(load)
  );

  // Data changes only in load slots, otherwise it is held
  assign pixel_take = pclk_rise && load;
  assign data_next = (panel_mode == MODE_4BIT) ?
                     {pixel_data[3:0], 4'h0} : pixel_data;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pos_reg <= 11'h000;
      line_reg <= 11'h000;
      line_pulse_reg <= 1'b0;
      frame_reg <= 1'b0;
      bias_reg <= 1'b0;
    end else if (pclk_rise) begin
      pos_reg <= pos_next;
      line_reg <= line_next;
      line_pulse_reg <= line_pulse_next;
      frame_reg <= frame_next;
      bias_reg <= bias_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_a_reg <= 1'b0;
      shift_b_reg <= 1'b1;
      data_reg <= 8'h00;
    end else if (pclk_rise) begin
      shift_a_reg <= shift_a;
      shift_b_reg <= shift_b || (panel_mode != MODE_8BIT_TWO_CLK);
      if (load) begin
        data_reg <= data_next;
      end
    end
  end

  // 4-bit shift is high only in the high half of the pixel clock
  assign shift_clock = (panel_mode == MODE_4BIT) ?
                       (shift_a_reg & pclk_level) : shift_a_reg;
  assign shift_clock_2 = shift_b_reg;
  assign frame_pulse = frame_reg;
  assign line_pulse = line_pulse_reg;
  assign backplane_bias_alternate = bias_reg;
  assign panel_pixel_bus = data_reg;
endmodule // lcd_panel_timing
`default_nettype wire

/* File: src/pclk_edge.sv */
// Pixel clock sampler: two-flop synchroniser, delayed copy and rise detect.
// Assumes the pixel clock is far slower than clk.
`timescale 1ns/1ps
`default_nettype none
module pclk_edge (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pixel_clock_pin,
  output logic pclk_level,
  output logic pclk_rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pixel_clock_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign pclk_level = last_reg;
  assign pclk_rise = sync_reg & ~last_reg;
endmodule // pclk_edge
`default_nettype wire

/* File: src/shift_wave.sv */
// Shift clock shapes and data load slots for one pixel-clock position.
// Assumes q counts pixel clocks from the end of the shift idle time.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_timing_defs.svh"
module shift_wave
  import lcd_timing_pkg::*;
(
  input wire panel_mode_e mode,
  input wire logic run,
  input wire hpos_t q,
  input wire hpos_t span,
  output logic shift_a,
  output logic shift_b,
  output logic load
);
  hpos_t lead;
  hpos_t q_lead;
  logic in_span;
  logic two_run;
  logic one_run;
  logic two_a;

  assign lead = hpos_t'(`TWO_CLK_LEAD);
  assign q_lead = q - lead;
  assign in_span = run && (q < span);
  // Primary rises and secondary falls together, two clocks past the idle
  assign two_run = run && (q >= lead) && (q < span + lead);
  assign two_a = two_run && !q_lead[1];
  // First high phase stretched to two clocks, then one low one high;
  // ends one period early so the last fall keeps its lead on the line
  assign one_run = run && (q < span - 11'h001)
                   && ((q < lead) || q[0]);

  always_comb begin
    shift_a = 1'b0;
    shift_b = 1'b0;
    load = 1'b0;
    case (mode)
      MODE_4BIT: begin
        shift_a = in_span;
        load = in_span;
      end
      MODE_8BIT_TWO_CLK: begin
        shift_a = two_a;
        shift_b = !two_a;
        load = in_span && q[0];
      end
      MODE_8BIT_ONE_CLK: begin
        shift_a = one_run;
        load = one_run && q[0];
      end
      default: begin
        shift_a = 1'b0;
        shift_b = 1'b0;
        load = 1'b0;
      end
    endcase
  end
endmodule // shift_wave
`default_nettype wire

/* File: tb/panel_model.sv */
// Passive panel: counts lines and shifting lines per frame, shift falls per line.
// Assumes counts are trusted only from the second frame on.
`timescale 1ns/1ps
`default_nettype none
module panel_model (
  input wire logic clk,
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic shift_clock,
  output logic report,
  output logic [15:0] lines,
  output logic [15:0] act,
  output logic [15:0] period,
  output logic [15:0] falls
);
  logic fp_d = 1'b0;
  logic lp_d = 1'b0;
  logic sc_d = 1'b0;
  logic [15:0] ln = 16'h0000;
  logic [15:0] ac = 16'h0000;
  logic [15:0] tk = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  always @(posedge clk) begin
    report <= 1'b0;
    tk <= tk + 16'h0001;
    if (sc_d && !shift_clock) cnt <= cnt + 16'h0001;
    if (lp_d && !line_pulse) begin
      period <= tk;
      tk <= 16'h0001;
      ln <= ln + 16'h0001;
      cnt <= 16'h0000;
      if (cnt != 16'h0000) begin
        ac <= ac + 16'h0001;
        falls <= cnt;
      end
    end
    if (!fp_d && frame_pulse) begin
      report <= 1'b1;
      lines <= ln;
      act <= ac;
      ln <= 16'h0000;
      ac <= 16'h0000;
    end
    fp_d <= frame_pulse;
    lp_d <= line_pulse;
    sc_d <= shift_clock;
  end
endmodule // panel_model
`default_nettype wire

/* File: tb/panel_timing_properties.sv */
// Timing checks on the frame, line, shift and data outputs.
// Assumes a pixel clock of eight clk periods.
`timescale 1ns/1ps
`default_nettype none
module panel_timing_properties
  import lcd_timing_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire panel_mode_e panel_mode,
  input wire logic frame_pulse,
  input wire logic line_pulse,
  input wire logic shift_clock,
  input wire logic shift_clock_2,
  input wire logic backplane_bias_alternate,
  input wire logic [7:0] panel_pixel_bus
);
  logic [15:0] gap_reg;
  logic [15:0] lp_reg;
  logic [15:0] hi_reg;
  logic [15:0] sf_reg;
  wire four = panel_mode == MODE_4BIT;
  wire two = panel_mode == MODE_8BIT_TWO_CLK;
  wire one = panel_mode == MODE_8BIT_ONE_CLK;
  // Clocks since line fall, high runs of line pulse and shift clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 16'hFFFF;
      lp_reg <= 16'h0000;
      hi_reg <= 16'h0000;
      sf_reg <= 16'hFFFF;
    end else begin
      sf_reg <= ($fell(shift_clock) || $fell(shift_clock_2)) ? 16'h0001 :
                sf_reg + 16'(sf_reg != 16'hFFFF);
      gap_reg <= $fell(line_pulse) ? 16'h0001 :
                 gap_reg + 16'(gap_reg != 16'hFFFF);
      lp_reg <= line_pulse ? lp_reg + 16'h0001 : 16'h0000;
      hi_reg <= shift_clock ? hi_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_line_wide; $fell(line_pulse) |-> lp_reg >= 16'h0048; endproperty
  a_line_wide: assert property (p_line_wide) else $error("line short");
  property p_frame_hold; $fell(frame_pulse) |-> gap_reg >= 16'h0048;
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("hold");
  property p_bias; (four || one) && $rose(line_pulse) |->
    $stable(backplane_bias_alternate)[*8] ##1
    $changed(backplane_bias_alternate); endproperty
  a_bias: assert property (p_bias) else $error("bias timing");
  property p_idle; gap_reg < 16'h00B8 |->
    !shift_clock && $stable(panel_pixel_bus); endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_two_period; two && $fell(shift_clock) |-> hi_reg == 16'h0010;
  endproperty
  a_two_period: assert property (p_two_period) else $error("period");
  property p_two_first; two && $rose(shift_clock) && gap_reg < 16'h00D0 |->
    gap_reg == 16'h00C8 && $fell(shift_clock_2); endproperty
  a_two_first: assert property (p_two_first) else $error("first");
  property p_four; four && $fell(shift_clock) |->
    hi_reg == 16'h0004 && panel_pixel_bus[3:0] == 4'h0; endproperty
  a_four: assert property (p_four) else $error("nibble shift");
  property p_hold; (two || one) && ($fell(shift_clock) ||
    $fell(shift_clock_2)) |-> $stable(panel_pixel_bus)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("data hold");
  property p_one_first; one && $rose(shift_clock) && gap_reg < 16'h00C0 |->
    gap_reg == 16'h00B8 ##16 $fell(shift_clock); endproperty
  a_one_first: assert property (p_one_first) else $error("first");
  property p_shift_lead; (four || one) && $rose(line_pulse) |->
    !$fell(shift_clock) && sf_reg >= (one ? 16'h0008 : 16'h0004);
  endproperty
  a_shift_lead: assert property (p_shift_lead) else $error("lead");
  property p_shift_tail; $fell(line_pulse) |->
    sf_reg >= (four ? 16'h004C : one ? 16'h0050 : 16'h0048); endproperty
  a_shift_tail: assert property (p_shift_tail) else $error("tail");
  c_frame: cover property ($rose(frame_pulse));
  c_two: cover property (two && $fell(shift_clock_2));
  c_one: cover property (one && $fell(shift_clock));
endmodule // panel_timing_properties
bind lcd_panel_timing panel_timing_properties panel_timing_properties_inst (
  .clk(clk), .resetn(resetn), .panel_mode(panel_mode),
  .frame_pulse(frame_pulse), .line_pulse(line_pulse),
  .shift_clock(shift_clock), .shift_clock_2(shift_clock_2),
  .backplane_bias_alternate(backplane_bias_alternate),
  .panel_pixel_bus(panel_pixel_bus));
`default_nettype wire

/* File: tb/testbench.sv */
// Bench: programs each panel mode and compares the panel's frame counts.
// Assumes a 100 MHz clk and an 80 ns pixel clock of unrelated phase.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_timing_defs.svh"
module testbench;
  import lcd_timing_pkg::*;
  typedef struct packed {
    logic [15:0] lines;
    logic [15:0] act;
    logic [15:0] period;
    logic [15:0] falls;
  } note_s;
  logic clk, resetn, pixel_clock_pin, reg_wr, pixel_take, frame_pulse;
  logic line_pulse, shift_clock, shift_clock_2, backplane_bias_alternate;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pixel_data, panel_pixel_bus;
  logic report;
  logic [15:0] lines, act, period, falls;
  panel_mode_e panel_mode;
  note_s notes[$];
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 17107;
  logic [7:0] pix_q[$];
  logic sc_n, sc2_n, lp_n;
  lcd_panel_timing lcd_panel_timing_inst (
    .clk(clk), .resetn(resetn), .pixel_clock_pin(pixel_clock_pin),
    .panel_mode(panel_mode), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pixel_data(pixel_data),
    .pixel_take(pixel_take), .frame_pulse(frame_pulse),
    .line_pulse(line_pulse), .shift_clock(shift_clock),
    .shift_clock_2(shift_clock_2),
    .backplane_bias_alternate(backplane_bias_alternate),
    .panel_pixel_bus(panel_pixel_bus));
  panel_model panel_model_inst (
    .clk(clk), .frame_pulse(frame_pulse), .line_pulse(line_pulse),
    .shift_clock(shift_clock), .report(report), .lines(lines), .act(act),
    .period(period), .falls(falls));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    pixel_clock_pin = 1'b0;
    #3.3;
    forever #40 pixel_clock_pin = ~pixel_clock_pin;
  end
  always @(negedge clk) pixel_data <= 8'($random(seed));
  task automatic check(input string what, input logic [15:0] seen, want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_report;
    int i;
    for (i = 0; i < 20000 && report !== 1'b1; i++) @(negedge clk);
    if (report !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    @(negedge clk);
  endtask
  task automatic run_mode(input panel_mode_e m);
    logic [7:0] addr [6];
    logic [7:0] val [6];
    logic [15:0] w, b, h, v, horizontal_active_time;
    logic [7:0] r;
    note_s n;
    int i;
    addr = '{`HACT_WIDTH_OFF, `VACT_LOW_OFF, `VACT_HIGH_OFF, `HBLANK_OFF,
             `VBLANK_OFF, 8'h07};
    w = 16'({$random(seed)} % 3);
    b = 16'({$random(seed)} % 3);
    h = 16'({$random(seed)} % 4);
    v = 16'({$random(seed)} % 4);
    // A one-line frame keeps the frame pulse high, so no frame edge
    if (h == 16'h0000 && v == 16'h0000) begin
      v = 16'h0001;
    end
    r = 8'($random(seed));
    // Spare upper bits are set at random and must not alter timing
    val = '{{r[7], w[6:0]}, h[7:0], {r[5:0], 2'b00}, {r[2:0], b[4:0]},
            {r[1:0], v[5:0]}, 8'h00};
    panel_mode = m;
    resetn = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    for (i = 0; i < 5; i++) begin
      reg_wr = 1'b1;
      reg_addr = addr[i];
      reg_wdata = val[i];
      @(negedge clk);
    end
    reg_wr = 1'b0;
    for (i = 0; i < 6; i++) begin
      reg_addr = addr[i];
      @(negedge clk);
      check("reg_rdata", {8'h00, reg_rdata}, {8'h00, val[i]});
    end
    horizontal_active_time = (w + 16'h0001) * 16'h0008;
    n.period = (horizontal_active_time + (b + 16'h0004) * 16'h0008) * 16'h0008;
    n.lines = h + v + 16'h0001;
    n.act = h + 16'h0001;
    n.falls = (m == MODE_4BIT) ? horizontal_active_time :
              (m == MODE_8BIT_TWO_CLK) ? horizontal_active_time >> 2 :
              (horizontal_active_time >> 1) - 16'h0001;
    wait_report();
    wait_report();
    notes.push_back(n);
    notes.push_back(n);
    wait_report();
    wait_report();
  endtask
  always @(negedge clk) begin
    note_s n;
    if (report === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      check("lines", lines, n.lines);
      check("active lines", act, n.act);
      check("line period", period, n.period);
      check("shift falls", falls, n.falls);
    end
  end
  // Notes each byte the design takes, as the panel should see it
  always @(posedge clk) begin
    if (resetn !== 1'b1) begin
      pix_q.delete();
    end else if (pixel_take === 1'b1) begin
      pix_q.push_back((panel_mode == MODE_4BIT) ?
                      {pixel_data[3:0], 4'h0} : pixel_data);
    end
  end
  // Panel side: compares the bus at every shift fall
  always @(negedge clk) begin
    logic [7:0] want;
    if (resetn === 1'b1 && ((sc_n === 1'b1 && shift_clock === 1'b0) ||
        (sc2_n === 1'b1 && shift_clock_2 === 1'b0 &&
        panel_mode == MODE_8BIT_TWO_CLK))) begin
      want = (pix_q.size() > 0) ? pix_q.pop_front() : 8'hXX;
      check("pixel bus", {8'h00, panel_pixel_bus}, {8'h00, want});
    end
    if (resetn === 1'b1 && lp_n === 1'b1 && line_pulse === 1'b0) begin
      check("pixels left", 16'(pix_q.size()), 16'h0000);
    end
    sc_n <= shift_clock;
    sc2_n <= shift_clock_2;
    lp_n <= line_pulse;
  end
  initial begin
    resetn = 1'b0;
    panel_mode = MODE_4BIT;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    run_mode(MODE_4BIT);
    run_mode(MODE_8BIT_TWO_CLK);
    run_mode(MODE_8BIT_ONE_CLK);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
